// file: verilog/flash_map.svh
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH
// Program memory: flash occupies 0x2000-0x2FFF, selected by address bits [13:12]
`define FLASH_PM_PAGE      2'h2
`define SECT1_FIRST        12'h100
`define SECT2_FIRST        12'h200
`define SECT0_LAST         12'h0FF
`define SECT1_LAST         12'h1FF
`define FLASH_LAST_WORD    12'hFFF
`define FLASH_FIRST_WORD   12'h000
`define APP_ENTRY_ADDR     14'h2200
`define MONITOR_ENTRY_ADDR 14'h0800
// Data memory: peripheral registers at 0x2000-0x20FF, selected by bits [13:8]
`define PERIPH_PAGE        6'h20
`define REG_FLASH_CTRL     8'h10
`define REG_FLASH_ADDR     8'h11
`define REG_FLASH_DLO      8'h12
`define REG_FLASH_DHI      8'h13
// Control register fields
`define CTRL_CMD_LSB       0
`define CTRL_CMD_MSB       2
`define CTRL_START_BIT     3
`define CTRL_BUSY_BIT      4
`define CTRL_LOCK_BIT      5
`define CTRL_NVIDX_LSB     8
`define CTRL_NVIDX_MSB     9
`define CTRL_RESET         16'h0000
`define REG16_RESET        16'h0000
`define ERASED_WORD        24'hFFFFFF
`define NV_ERASED_BYTES    32'h00000000
`define READ_ZERO16        16'h0000
`define READ_ZERO24        24'h000000
`define ZERO8              8'h00
`endif

// file: verilog/flash_pkg.sv
package flash_pkg;
  typedef enum logic [2:0] {
    ST_IDLE       = 3'h1,
    ST_ERASE_ALL  = 3'h2,
    ST_ERASE_SECT = 3'h4
  } flash_state_e;

  typedef enum logic [2:0] {
    CMD_NONE         = 3'h0,
    CMD_PROGRAM      = 3'h1,
    CMD_READ         = 3'h2,
    CMD_ERASE_SECT   = 3'h3,
    CMD_NV_READ      = 3'h4,
    CMD_NV_WRITE     = 3'h5,
    CMD_UNLOCK_ERASE = 3'h6,
    CMD_UNLOCK_KEEP  = 3'h7
  } flash_cmd_e;

  typedef enum logic [1:0] {
    DBG_READ     = 2'h0,
    DBG_PROGRAM  = 2'h1,
    DBG_NV_WRITE = 2'h2,
    DBG_SET_LOCK = 2'h3
  } dbg_op_e;

  typedef struct packed {
    logic [23:0] fetch_data;
    logic [23:0] svc_data;
    logic [31:0] nv;
    logic        lock;
  } store_s;

  typedef struct packed {
    flash_state_e state;
    logic [15:0]  ctrl;
    logic [15:0]  addr;
    logic [15:0]  dlo;
    logic [15:0]  dhi;
    logic [11:0]  walk;
    logic [11:0]  walk_last;
    logic         core_rd_pend;
    logic         dbg_rd_pend;
    logic         dbg_ack;
    logic         dbg_refused;
    logic [23:0]  dbg_rdata;
    logic         pm_hit;
    logic [15:0]  dm_rdata;
    logic         boot_valid;
    logic         boot_done;
    logic [13:0]  boot_addr;
    logic         blank_s1;
    logic         blank_s2;
  } top_s;
endpackage : flash_pkg

// file: verilog/flash_store.sv
`timescale 1ns/100ps
`include "flash_map.svh"
// Nonvolatile content: no reset, survives every system reset
module flash_store #(
  parameter int WORDS = 4096
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_blank,
  input  wire logic        i_we,
  input  wire logic [11:0] i_waddr,
  input  wire logic [23:0] i_wdata,
  input  wire logic [11:0] i_fetch_addr,
  output logic      [23:0] o_fetch_data,
  input  wire logic [11:0] i_svc_addr,
  output logic      [23:0] o_svc_data,
  input  wire logic        i_nv_we,
  input  wire logic [1:0]  i_nv_idx,
  input  wire logic [7:0]  i_nv_wdata,
  output logic      [31:0] o_nv_bytes,
  input  wire logic        i_lock_set,
  input  wire logic        i_lock_clr,
  output logic             o_lock
);
  logic [23:0]      mem [0:WORDS-1];
  flash_pkg::store_s st_reg;
  flash_pkg::store_s st_next;

  always_comb begin
    st_next            = st_reg;
    st_next.fetch_data = mem[i_fetch_addr];
    st_next.svc_data   = mem[i_svc_addr];
    if (i_nv_we) begin
      st_next.nv[{i_nv_idx, 3'h0} +: 8] = i_nv_wdata;
    end
    if (i_lock_set) begin
      st_next.lock = 1'b1;
    end
    if (i_lock_clr) begin
      st_next.lock = 1'b0;
    end
    // Factory blank empties the byte registers and drops the code
    if (i_blank) begin
      st_next.nv   = `NV_ERASED_BYTES;
      st_next.lock = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st_reg <= st_next;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_fetch_data = st_reg.fetch_data;
  assign o_svc_data   = st_reg.svc_data;
  assign o_nv_bytes   = st_reg.nv;
  assign o_lock       = st_reg.lock;
endmodule : flash_store

// file: verilog/flash_sector_map_boot_lock.sv
`timescale 1ns/100ps
`include "flash_map.svh"
module flash_sector_map_boot_lock #(
  parameter int WORDS = 4096
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_blank,
  input  wire logic        i_pm_rd,
  input  wire logic [13:0] i_pm_addr,
  output logic      [23:0] o_pm_rdata,
  output logic             o_pm_hit,
  input  wire logic        i_dm_rd,
  input  wire logic        i_dm_wr,
  input  wire logic [13:0] i_dm_addr,
  input  wire logic [15:0] i_dm_wdata,
  output logic      [15:0] o_dm_rdata,
  input  wire logic        i_dbg_req,
  input  wire logic [1:0]  i_dbg_op,
  input  wire logic [11:0] i_dbg_addr,
  input  wire logic [23:0] i_dbg_wdata,
  output logic             o_dbg_ack,
  output logic             o_dbg_refused,
  output logic      [23:0] o_dbg_rdata,
  output logic             o_boot_valid,
  output logic      [13:0] o_boot_addr,
  output logic             o_locked,
  output logic             o_busy
);
  flash_pkg::top_s       st_reg;
  flash_pkg::top_s       st_next;
  flash_pkg::flash_cmd_e cmd;
  logic        we;
  logic [11:0] waddr;
  logic [23:0] wdata;
  logic [11:0] svc_addr;
  logic        nv_we;
  logic [1:0]  nv_idx;
  logic [7:0]  nv_wdata;
  logic        lock_set;
  logic        lock_clr;
  logic        core_clr;
  logic        core_start;
  logic        dm_in_region;
  logic [23:0] fetch_data;
  logic [23:0] svc_data;
  logic [31:0] nv_bytes;
  logic        lock;

  // Sector containing a word: returns {first, last}
  function automatic logic [23:0] sector_bounds(input logic [11:0] a);
    if (a < `SECT1_FIRST) begin
      sector_bounds = {`FLASH_FIRST_WORD, `SECT0_LAST};
    end else if (a < `SECT2_FIRST) begin
      sector_bounds = {`SECT1_FIRST, `SECT1_LAST};
    end else begin
      sector_bounds = {`SECT2_FIRST, `FLASH_LAST_WORD};
    end
  endfunction : sector_bounds

  assign dm_in_region = (i_dm_addr[13:8] == `PERIPH_PAGE);
  assign core_start   = i_dm_wr && dm_in_region && (i_dm_addr[7:0] == `REG_FLASH_CTRL) &&
                        i_dm_wdata[`CTRL_START_BIT] && (st_reg.state == flash_pkg::ST_IDLE);
  assign cmd          = flash_pkg::flash_cmd_e'(i_dm_wdata[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);

  always_comb begin
    st_next             = st_reg;
    st_next.blank_s1    = i_blank;
    st_next.blank_s2    = st_reg.blank_s1;
    st_next.dbg_ack     = 1'b0;
    st_next.dbg_refused = 1'b0;
    st_next.boot_valid  = 1'b0;
    st_next.core_rd_pend = 1'b0;
    st_next.dbg_rd_pend = 1'b0;
    we       = 1'b0;
    waddr    = st_reg.walk;
    wdata    = `ERASED_WORD;
    svc_addr = st_reg.addr[11:0];
    nv_we    = 1'b0;
    nv_idx   = i_dm_wdata[`CTRL_NVIDX_MSB:`CTRL_NVIDX_LSB];
    nv_wdata = st_reg.dlo[7:0];
    lock_set = 1'b0;
    lock_clr = 1'b0;
    core_clr = 1'b0;
    // First cycle after reset: pick the boot vector from the stored code
    if (!st_reg.boot_done) begin
      st_next.boot_done  = 1'b1;
      st_next.boot_valid = 1'b1;
      st_next.boot_addr  = lock ? `APP_ENTRY_ADDR : `MONITOR_ENTRY_ADDR;
    end
    // Instruction fetch; reserved program space returns zero
    st_next.pm_hit = i_pm_rd && (i_pm_addr[13:12] == `FLASH_PM_PAGE);
    // Register readback; the control word carries live busy and lock
    st_next.dm_rdata = `READ_ZERO16;
    if (i_dm_rd && dm_in_region) begin
      case (i_dm_addr[7:0])
        `REG_FLASH_CTRL: begin
          st_next.dm_rdata = st_reg.ctrl;
          st_next.dm_rdata[`CTRL_BUSY_BIT] = (st_reg.state != flash_pkg::ST_IDLE);
          st_next.dm_rdata[`CTRL_LOCK_BIT] = lock;
        end
        `REG_FLASH_ADDR: st_next.dm_rdata = st_reg.addr;
        `REG_FLASH_DLO:  st_next.dm_rdata = st_reg.dlo;
        `REG_FLASH_DHI:  st_next.dm_rdata = st_reg.dhi;
        default:         st_next.dm_rdata = `READ_ZERO16;
      endcase
    end
    // Plain register writes; ignored while an erase walk runs
    if (i_dm_wr && dm_in_region && (st_reg.state == flash_pkg::ST_IDLE)) begin
      case (i_dm_addr[7:0])
        `REG_FLASH_CTRL: st_next.ctrl = i_dm_wdata & ~(16'h0001 << `CTRL_START_BIT);
        `REG_FLASH_ADDR: st_next.addr = i_dm_wdata;
        `REG_FLASH_DLO:  st_next.dlo  = i_dm_wdata;
        `REG_FLASH_DHI:  st_next.dhi  = i_dm_wdata;
        default:         st_next.ctrl = st_reg.ctrl;
      endcase
    end
    // Results of a read issued the cycle before
    if (st_reg.core_rd_pend) begin
      st_next.dhi = svc_data[23:8];
      st_next.dlo = {`ZERO8, svc_data[7:0]};
    end
    if (st_reg.dbg_rd_pend) begin
      st_next.dbg_rdata = svc_data;
      st_next.dbg_ack   = 1'b1;
    end
    case (st_reg.state)
      flash_pkg::ST_IDLE: begin
        if (core_start) begin
          case (cmd)
            flash_pkg::CMD_PROGRAM: begin
              we    = 1'b1;
              waddr = st_reg.addr[11:0];
              wdata = {st_reg.dhi, st_reg.dlo[7:0]};
            end
            flash_pkg::CMD_READ: st_next.core_rd_pend = 1'b1;
            flash_pkg::CMD_ERASE_SECT: begin
              {st_next.walk, st_next.walk_last} = sector_bounds(st_reg.addr[11:0]);
              st_next.state = flash_pkg::ST_ERASE_SECT;
            end
            flash_pkg::CMD_NV_READ: st_next.dlo = {`ZERO8, nv_bytes[{nv_idx, 3'h0} +: 8]};
            flash_pkg::CMD_NV_WRITE: nv_we = 1'b1;
            flash_pkg::CMD_UNLOCK_ERASE: begin
              st_next.walk      = `FLASH_FIRST_WORD;
              st_next.walk_last = `FLASH_LAST_WORD;
              st_next.state     = flash_pkg::ST_ERASE_ALL;
            end
            flash_pkg::CMD_UNLOCK_KEEP: begin
              lock_clr = 1'b1;
              core_clr = 1'b1;
            end
            default: we = 1'b0;
          endcase
        end
        // Link requests: refused outright while locked or colliding with the core
        if (i_dbg_req) begin
          if (lock || core_start) begin
            st_next.dbg_refused = 1'b1;
          end else begin
            case (flash_pkg::dbg_op_e'(i_dbg_op))
              flash_pkg::DBG_READ: begin
                svc_addr            = i_dbg_addr;
                st_next.dbg_rd_pend = 1'b1;
              end
              flash_pkg::DBG_PROGRAM: begin
                we              = 1'b1;
                waddr           = i_dbg_addr;
                wdata           = i_dbg_wdata;
                st_next.dbg_ack = 1'b1;
              end
              flash_pkg::DBG_NV_WRITE: begin
                nv_we           = 1'b1;
                nv_idx          = i_dbg_addr[1:0];
                nv_wdata        = i_dbg_wdata[7:0];
                st_next.dbg_ack = 1'b1;
              end
              flash_pkg::DBG_SET_LOCK: begin
                lock_set        = 1'b1;
                st_next.dbg_ack = 1'b1;
              end
              default: st_next.dbg_refused = 1'b1;
            endcase
          end
        end
      end
      flash_pkg::ST_ERASE_ALL, flash_pkg::ST_ERASE_SECT: begin
        // One word per cycle; the link is shut out until the walk ends
        we = 1'b1;
        st_next.dbg_refused = i_dbg_req;
        st_next.walk = st_reg.walk + 12'h001;
        if (st_reg.walk == st_reg.walk_last) begin
          st_next.state = flash_pkg::ST_IDLE;
          if (st_reg.state == flash_pkg::ST_ERASE_ALL) begin
            lock_clr = 1'b1;
            core_clr = 1'b1;
          end
        end
      end
      default: st_next.state = flash_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{state: flash_pkg::ST_IDLE, ctrl: `CTRL_RESET, addr: `REG16_RESET, dlo: `REG16_RESET,
                 dhi: `REG16_RESET, walk: `FLASH_FIRST_WORD, walk_last: `FLASH_FIRST_WORD,
                 dbg_rdata: `READ_ZERO24, dm_rdata: `READ_ZERO16, boot_addr: `MONITOR_ENTRY_ADDR,
                 default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  flash_store #(
    .WORDS (WORDS)
  ) u_store (
    .i_sys_clk    (i_sys_clk),
    .i_blank      (st_reg.blank_s2),
    .i_we         (we),
    .i_waddr      (waddr),
    .i_wdata      (wdata),
    .i_fetch_addr (i_pm_addr[11:0]),
    .o_fetch_data (fetch_data),
    .i_svc_addr   (svc_addr),
    .o_svc_data   (svc_data),
    .i_nv_we      (nv_we),
    .i_nv_idx     (nv_idx),
    .i_nv_wdata   (nv_wdata),
    .o_nv_bytes   (nv_bytes),
    .i_lock_set   (lock_set),
    .i_lock_clr   (lock_clr),
    .o_lock       (lock)
  );

  assign o_pm_rdata    = st_reg.pm_hit ? fetch_data : `READ_ZERO24;
  assign o_pm_hit      = st_reg.pm_hit;
  assign o_dm_rdata    = st_reg.dm_rdata;
  assign o_dbg_ack     = st_reg.dbg_ack;
  assign o_dbg_refused = st_reg.dbg_refused;
  assign o_dbg_rdata   = st_reg.dbg_rdata;
  assign o_boot_valid  = st_reg.boot_valid;
  assign o_boot_addr   = st_reg.boot_addr;
  assign o_locked      = lock;
  assign o_busy        = (st_reg.state != flash_pkg::ST_IDLE);

  a_sector_top_bound: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (core_start && cmd == flash_pkg::CMD_ERASE_SECT && st_reg.addr[11:0] >= `SECT2_FIRST)
      |=> (st_reg.walk == `SECT2_FIRST) && (st_reg.walk_last == `FLASH_LAST_WORD))
    else $error("sector 2 erase bounds wrong");
  a_pm_flash_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_pm_rd && i_pm_addr[13:12] == `FLASH_PM_PAGE) |=> o_pm_hit)
    else $error("flash fetch not decoded");
  a_reg_lock_view: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dm_rd && dm_in_region && i_dm_addr[7:0] == `REG_FLASH_CTRL)
      |=> o_dm_rdata[`CTRL_LOCK_BIT] == $past(lock))
    else $error("control readback lock bit wrong");
  a_boot_app_vec: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_boot_valid && o_locked) |-> o_boot_addr == `APP_ENTRY_ADDR)
    else $error("locked boot did not go to application");
  a_dbg_refuse_lock: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dbg_req && lock) |-> !(we && (st_reg.state == flash_pkg::ST_IDLE) && !core_start)
      ##1 (o_dbg_refused && !o_dbg_ack))
    else $error("debug access served while locked");
  a_lock_clear_src: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (lock_clr) |-> core_clr)
    else $error("security code cleared from link");
  a_erase_then_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (lock_clr && st_reg.state == flash_pkg::ST_ERASE_ALL) |-> (st_reg.walk == `FLASH_LAST_WORD) && we)
    else $error("code cleared before full erase");
  a_keep_no_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (core_start && cmd == flash_pkg::CMD_UNLOCK_KEEP) |-> !we ##1 (st_reg.state == flash_pkg::ST_IDLE))
    else $error("keep unlock touched flash");
  a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dm_rd && !dm_in_region) |=> o_dm_rdata == `READ_ZERO16)
    else $error("reserved data read not zero");
endmodule : flash_sector_map_boot_lock

// file: bench/flash_link_model.sv
`timescale 1ns/100ps
// Programming-link side: one request pulse per call, answer polled over a few edges
module flash_link_model (
  input  wire logic        i_sys_clk,
  output logic             o_req,
  output logic      [1:0]  o_op,
  output logic      [11:0] o_addr,
  output logic      [23:0] o_wdata,
  input  wire logic        i_ack,
  input  wire logic        i_refused,
  input  wire logic [23:0] i_rdata
);
  logic active;

  initial begin
    active  = 1'b0;
    o_req   = 1'b0;
    o_op    = 2'h0;
    o_addr  = 12'h000;
    o_wdata = 24'h000000;
  end

  // Released address and data lines flip every cycle so a stale word can never pass for a fresh one
  always @(posedge i_sys_clk) begin
    #2;
    if (!active) begin
      o_addr  = ~o_addr;
      o_wdata = ~o_wdata;
    end
  end

  task run(input logic [1:0] op, input logic [11:0] addr, input logic [23:0] wdata,
           output logic ack, output logic refused, output logic [23:0] rdata);
    int n;
    @(posedge i_sys_clk);
    #1;
    active  = 1'b1;
    o_req   = 1'b1;
    o_op    = op;
    o_addr  = addr;
    o_wdata = wdata;
    @(posedge i_sys_clk);
    #1;
    o_req   = 1'b0;
    active  = 1'b0;
    ack     = i_ack;
    refused = i_refused;
    rdata   = i_rdata;
    for (n = 0; n < 3 && !(ack || refused); n++) begin
      @(posedge i_sys_clk);
      #1;
      ack     = i_ack;
      refused = i_refused;
      rdata   = i_rdata;
    end
  endtask : run
endmodule : flash_link_model

// file: bench/flash_sector_map_boot_lock_tb_top.sv
`timescale 1ns/100ps
`include "flash_map.svh"
module flash_sector_map_boot_lock_tb_top;
  logic        clk, rst, blank, pm_rd, dm_rd, dm_wr, pm_hit, dbg_req, ack, refused;
  logic        boot_valid, locked, busy;
  logic        ack_w, ref_w;
  logic [13:0] pm_addr, dm_addr, boot_addr;
  logic [15:0] dm_wdata, dm_rdata, seed, d, lo, hi;
  logic [23:0] pm_rdata, dbg_rdata, dbg_wdata, w, rd;
  logic [11:0] dbg_addr;
  logic [11:0] la [10];
  logic [7:0]  nb [4];
  logic [1:0]  dbg_op;
  logic [23:0] img [logic [11:0]];
  int          failures, total_checks, cycles, k;

  flash_sector_map_boot_lock #(.WORDS(4096)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_blank(blank), .i_pm_rd(pm_rd), .i_pm_addr(pm_addr),
    .o_pm_rdata(pm_rdata), .o_pm_hit(pm_hit), .i_dm_rd(dm_rd), .i_dm_wr(dm_wr),
    .i_dm_addr(dm_addr), .i_dm_wdata(dm_wdata), .o_dm_rdata(dm_rdata), .i_dbg_req(dbg_req),
    .i_dbg_op(dbg_op), .i_dbg_addr(dbg_addr), .i_dbg_wdata(dbg_wdata), .o_dbg_ack(ack_w),
    .o_dbg_refused(ref_w), .o_dbg_rdata(dbg_rdata), .o_boot_valid(boot_valid),
    .o_boot_addr(boot_addr), .o_locked(locked), .o_busy(busy)
  );
  flash_link_model link (
    .i_sys_clk(clk), .o_req(dbg_req), .o_op(dbg_op), .o_addr(dbg_addr), .o_wdata(dbg_wdata),
    .i_ack(ack_w), .i_refused(ref_w), .i_rdata(dbg_rdata)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // Idle write data wanders so a dropped strobe cannot reuse the last value
  always @(posedge clk) begin
    #2;
    if (!dm_wr) dm_wdata = ~dm_wdata;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [23:0] exp_fetch(input logic [13:0] a);
    if (a[13:12] == `FLASH_PM_PAGE && img.exists(a[11:0])) return img[a[11:0]];
    return `READ_ZERO24;
  endfunction : exp_fetch

  task stop_test;
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task chk_data(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // Core writes drive the command sequences of the programming routines and one reserved-address probe
  task dm_write(input logic [13:0] a, input logic [15:0] v);
    @(posedge clk);
    #1;
    dm_wr    = 1'b1;
    dm_addr  = a;
    dm_wdata = v;
    @(posedge clk);
    #1;
    dm_wr = 1'b0;
  endtask : dm_write

  task dm_read(input logic [13:0] a, output logic [15:0] v);
    @(posedge clk);
    #1;
    dm_rd   = 1'b1;
    dm_addr = a;
    @(posedge clk);
    #1;
    dm_rd = 1'b0;
    v     = dm_rdata;
  endtask : dm_read

  task cmd(input logic [15:0] ctrl);
    dm_write({`PERIPH_PAGE, `REG_FLASH_CTRL}, ctrl);
    repeat (3) @(posedge clk);
  endtask : cmd

  task fetch(input logic [13:0] a);
    @(posedge clk);
    #1;
    pm_rd   = 1'b1;
    pm_addr = a;
    @(posedge clk);
    #1;
    pm_rd = 1'b0;
    chk_flag(pm_hit, a[13:12] == `FLASH_PM_PAGE);
    chk_data(pm_rdata, exp_fetch(a));
  endtask : fetch

  task link_chk(input logic [1:0] op, input logic [11:0] a, input logic [23:0] v, input logic ok);
    link.run(op, a, v, ack, refused, rd);
    chk_flag(ack, ok);
    chk_flag(refused, !ok);
    if (ok && op == 2'h0) chk_data(rd, img[a]);
  endtask : link_chk

  task core_word(input logic [11:0] a);
    dm_write({`PERIPH_PAGE, `REG_FLASH_ADDR}, {4'h0, a});
    cmd(16'h000A);
    dm_read({`PERIPH_PAGE, `REG_FLASH_DLO}, lo);
    dm_read({`PERIPH_PAGE, `REG_FLASH_DHI}, hi);
    chk_data({hi, lo[7:0]}, img[a]);
  endtask : core_word

  task wait_idle;
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk_flag(busy, 1'b0);
  endtask : wait_idle

  task reset_boot(input logic [13:0] exp_addr);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk_flag(boot_valid, 1'b1);
    chk_data(boot_addr, exp_addr);
  endtask : reset_boot

  initial begin
    clk          = 1'b0;
    rst          = 1'b1;
    blank        = 1'b1;
    pm_rd        = 1'b0;
    pm_addr      = 14'h0000;
    dm_rd        = 1'b0;
    dm_wr        = 1'b0;
    dm_addr      = 14'h0000;
    dm_wdata     = 16'h0000;
    seed         = 16'h0035;
    failures     = 0;
    total_checks = 0;
    cycles       = 0;
    la = '{12'h000, 12'h0FF, 12'h100, 12'h1FF, 12'h200, 12'hFFF, 0, 0, 0, 0};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    // Blank only acts out of reset; its synchroniser is held clear meanwhile
    repeat (4) @(posedge clk);
    #1;
    blank = 1'b0;
    reset_boot(`MONITOR_ENTRY_ADDR);
    for (k = 0; k < 4; k++) cmd(16'h000C | (k << 8));
    for (k = 0; k < 4; k++) begin
      cmd(16'h000C | (k << 8));
      dm_read({`PERIPH_PAGE, `REG_FLASH_DLO}, d);
      chk_data(d[7:0], `ZERO8);
    end
    // Application image lands at the entry word before any locking
    for (k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      if (k > 5) la[k] = seed[11:0];
      d = lfsr(seed);
      w = {seed, d[7:0]};
      img[la[k]] = w;
      link_chk(2'h1, la[k], w, 1'b1);
    end
    for (k = 0; k < 10; k++) begin
      link_chk(2'h0, la[k], 0, 1'b1);
      fetch({`FLASH_PM_PAGE, la[k]});
      core_word(la[k]);
    end
    fetch(14'h3000);
    fetch(14'h1FFF);
    dm_write(14'h2110, 16'hFFFF);
    dm_read(14'h2014, d);
    chk_data(d, `READ_ZERO16);
    dm_read(14'h2110, d);
    chk_data(d, `READ_ZERO16);
    dm_read({`PERIPH_PAGE, `REG_FLASH_CTRL}, d);
    chk_data(d[5:3], 3'h0);
    for (k = 0; k < 4; k++) begin
      seed  = lfsr(seed);
      nb[k] = seed[7:0];
      link_chk(2'h2, k[11:0], {16'h0, nb[k]}, 1'b1);
    end
    for (k = 0; k < 4; k++) begin
      cmd(16'h000C | (k << 8));
      dm_read({`PERIPH_PAGE, `REG_FLASH_DLO}, d);
      chk_data(d[7:0], nb[k]);
    end
    // Core-side program and byte-register write paths
    seed = lfsr(seed);
    img[la[9]] = {seed, 8'h5A};
    dm_write({`PERIPH_PAGE, `REG_FLASH_ADDR}, {4'h0, la[9]});
    dm_write({`PERIPH_PAGE, `REG_FLASH_DHI}, seed);
    dm_write({`PERIPH_PAGE, `REG_FLASH_DLO}, 16'h005A);
    cmd(16'h0009);
    core_word(la[9]);
    fetch({`FLASH_PM_PAGE, la[9]});
    nb[2] = seed[15:8];
    dm_write({`PERIPH_PAGE, `REG_FLASH_DLO}, {8'h00, nb[2]});
    cmd(16'h020D);
    cmd(16'h020C);
    dm_read({`PERIPH_PAGE, `REG_FLASH_DLO}, d);
    chk_data(d[7:0], nb[2]);
    link_chk(2'h3, 0, 0, 1'b1);
    chk_flag(locked, 1'b1);
    link_chk(2'h0, 12'h200, 0, 1'b0);
    link_chk(2'h1, 12'h000, 24'h123456, 1'b0);
    chk_flag(locked, 1'b1);
    reset_boot(`APP_ENTRY_ADDR);
    fetch(`APP_ENTRY_ADDR);
    fetch({`FLASH_PM_PAGE, 12'h000});
    cmd(16'h000F);
    chk_flag(locked, 1'b0);
    for (k = 0; k < 10; k++) fetch({`FLASH_PM_PAGE, la[k]});
    dm_write({`PERIPH_PAGE, `REG_FLASH_ADDR}, 16'h0150);
    dm_write({`PERIPH_PAGE, `REG_FLASH_CTRL}, 16'h000B);
    wait_idle();
    for (k = 0; k < 10; k++) if (la[k] >= `SECT1_FIRST && la[k] <= `SECT1_LAST) img[la[k]] = `ERASED_WORD;
    // Top sector erase, started from a random word inside it
    dm_write({`PERIPH_PAGE, `REG_FLASH_ADDR}, {7'h07, seed[8:0]});
    dm_write({`PERIPH_PAGE, `REG_FLASH_CTRL}, 16'h000B);
    wait_idle();
    for (k = 0; k < 10; k++) if (la[k] >= `SECT2_FIRST) img[la[k]] = `ERASED_WORD;
    for (k = 0; k < 10; k++) link_chk(2'h0, la[k], 0, 1'b1);
    link_chk(2'h3, 0, 0, 1'b1);
    dm_write({`PERIPH_PAGE, `REG_FLASH_CTRL}, 16'h000E);
    @(posedge clk);
    #1;
    chk_flag(busy, 1'b1);
    link_chk(2'h0, 12'h200, 0, 1'b0);
    chk_flag(locked, 1'b1);
    wait_idle();
    chk_flag(locked, 1'b0);
    for (k = 0; k < 10; k++) img[la[k]] = `ERASED_WORD;
    for (k = 0; k < 10; k++) link_chk(2'h0, la[k], 0, 1'b1);
    reset_boot(`MONITOR_ENTRY_ADDR);
    stop_test();
  end
endmodule : flash_sector_map_boot_lock_tb_top
